//--- design/impmc_pkg.sv
package impmc_pkg;

   // ****************************************************
   // clock and timing
   // ****************************************************
   localparam int CLK_NS = 10;
   localparam int TICK_NS = 39000;
   localparam int TICK_CYC = TICK_NS / CLK_NS;
   localparam int POWERUP_MS = 10;
   localparam int POWERUP_CYC = POWERUP_MS * 1_000_000 / CLK_NS;
   localparam int GYR_FSU_MS = 10;
   localparam int GYR_FSU_CYC = GYR_FSU_MS * 1_000_000 / CLK_NS;
   localparam int GYR_SU_MS = 55;
   localparam int GYR_SU_CYC = GYR_SU_MS * 1_000_000 / CLK_NS;
   localparam int SETTLE_TICKS = 2;

   // ****************************************************
   // register indexes, byte address is four times the index
   // ****************************************************
   localparam logic [7:0] IDX_ERR = 8'h02;
   localparam logic [7:0] IDX_PMU_STATUS = 8'h03;
   localparam logic [7:0] IDX_GYR_DATA = 8'h0C;
   localparam logic [7:0] IDX_ACC_DATA = 8'h12;
   localparam logic [7:0] IDX_TIME = 8'h18;
   localparam logic [7:0] IDX_QUEUE_DATA = 8'h24;
   localparam logic [7:0] IDX_ACCEL_RATE_FILTER_CONFIG = 8'h40;
   localparam logic [7:0] IDX_ROTATION_RATE_FILTER_CONFIG = 8'h42;
   localparam logic [7:0] IDX_QUEUE_DECIM = 8'h45;
   localparam logic [7:0] IDX_MODE_CMD = 8'h7E;

   // ****************************************************
   // fields and reset values
   // ****************************************************
   localparam int ACC_ODR_LSB = 0;
   localparam int ACC_AVG_LSB = 4;
   localparam int ACCEL_UNDERSAMPLE_ENABLE_BIT = 7;
   localparam int GYR_ODR_LSB = 0;
   localparam int QD_GYR_LSB = 0;
   localparam int QD_ACC_LSB = 4;
   localparam int MODE_ACC_LSB = 0;
   localparam int MODE_GYR_LSB = 2;
   localparam int ERR_ACC_BIT = 0;
   localparam int ERR_GYR_BIT = 1;
   localparam logic [7:0] ACCEL_RATE_FILTER_CONFIG_RST = 8'h28;
   localparam logic [7:0] ROTATION_RATE_FILTER_CONFIG_RST = 8'h28;
   localparam logic [7:0] QUEUE_DECIM_RST = 8'h00;

   // ****************************************************
   // rates as sensor time bit numbers
   // ****************************************************
   localparam logic [4:0] GYR_RATE_BIT = 5'h04 - 5'h02;
   localparam logic [4:0] ACC_RATE_BIT = 5'h04;
   localparam logic [4:0] ODR_BIT_BASE = 5'h10;
   localparam logic [3:0] ACC_ODR_MIN = 4'h1;
   localparam logic [3:0] ACC_ODR_MIN_NUS = 4'h5;
   localparam logic [3:0] ACC_ODR_MAX = 4'hC;
   localparam logic [3:0] GYR_ODR_MIN = 4'h6;
   localparam logic [3:0] GYR_ODR_MAX = 4'hD;

   // ****************************************************
   // modes
   // ****************************************************
   typedef enum logic [1:0] {
      ACC_SUSPEND = 2'h0,
      ACC_NORMAL = 2'h1,
      ACC_LOWPOWER = 2'h2
   } impmc_acc_mode_t;

   localparam logic [1:0] GYR_CMD_SUSPEND = 2'h0;
   localparam logic [1:0] GYR_CMD_NORMAL = 2'h1;
   localparam logic [1:0] GYR_CMD_FSU = 2'h3;

   typedef enum logic [3:0] {
      GYR_SUSPEND = 4'b0001,
      GYR_START = 4'b0010,
      GYR_NORMAL = 4'b0100,
      GYR_FSU = 4'b1000
   } impmc_gyr_state_t;

endpackage : impmc_pkg

//--- design/impmc_power_mode_control.sv
`timescale 1ns/1ps

// Function
// - both sensors start in suspend after power up
// - power up sequence finishes within 10 ms
// - raw sampling fixed at 6400 Hz rotation, 1600 Hz acceleration
// - each stream low passed and decimated to its configured output rate
// - extra frame dropping decimation feeds queue and interrupt path
// - sensor time advances in step with data register updates
// - accel normal, low power, suspend; gyro normal, suspend, fast start
// - suspend takes no samples and keeps data; host avoids queue reads
// - fast start keeps last sample, no acquisition, normal within 10 ms
// - only one sensor changes mode per step; host never goes diagonal
// - normal versus low power does not change accel output data
// - accel low power with undersampling alternates suspend and normal each interval
// - accel stays normal when the sleep gap is too short
// - undersampling makes normal mimic low power; low power swaps clock
// - active window is settling time plus averaged samples over 1600 Hz
// - power mode and output rate are set independently
// - averaging counts 1 to 128 in powers of two with undersampling
// - undersample bit set runs accel in undersampling mode
// - illegal configuration raises an error code

module impmc_power_mode_control
#(
   parameter int P_POWERUP_CYC = impmc_pkg::POWERUP_CYC,
   parameter int P_GYR_SU_CYC = impmc_pkg::GYR_SU_CYC,
   parameter int P_GYR_FSU_CYC = impmc_pkg::GYR_FSU_CYC
)
(
   input wire logic i_mclk,
   input wire logic i_rst,
   input wire logic [9:0] i_avs_address,
   input wire logic i_avs_read,
   input wire logic i_avs_write,
   input wire logic [31:0] i_avs_writedata,
   input wire logic [3:0] i_avs_byteenable,
   output logic [31:0] o_avs_readdata,
   output logic o_avs_waitrequest,
   input wire logic signed [15:0] i_accel_raw,
   input wire logic signed [15:0] i_gyro_raw,
   output logic o_accel_analog_on,
   output logic o_gyro_analog_on,
   output logic o_accel_lp_clock,
   output logic o_accel_update,
   output logic o_gyro_update,
   output logic o_queue_update,
   output logic o_ready
);

   impmc_pkg::impmc_acc_mode_t acc_mode_reg;
   impmc_pkg::impmc_gyr_state_t gyr_state_reg;
   logic [22:0] por_cnt_reg;
   logic ready_reg;
   logic [11:0] div_reg;
   logic tick;
   logic [23:0] time_reg;
   logic [23:0] next_time;
   logic ack_reg;
   logic req;
   logic wr_take;
   logic [7:0] idx;
   logic [31:0] rd_mux;
   logic [7:0] accel_rate_filter_config_reg;
   logic [7:0] rotation_rate_filter_config_reg;
   logic [7:0] queue_decim_reg;
   logic [7:0] err_reg;
   logic [22:0] gyr_timer_reg;
   logic [1:0] acc_req;
   logic [1:0] gyr_req;
   logic [1:0] gyr_code;
   logic acc_chg;
   logic gyr_chg;
   logic cmd_we;
   logic [3:0] acc_odr;
   logic [2:0] acc_avg;
   logic accel_undersample_enable;
   logic [4:0] acc_odr_bit;
   logic [4:0] gyr_odr_bit;
   logic [23:0] acc_mask;
   logic [23:0] acc_phase;
   logic [23:0] acc_window;
   logic [23:0] acc_interval;
   logic gap_short;
   logic awake;
   logic acc_active;
   logic acc_sample_en;
   logic gyr_active;
   logic acc_bad;
   logic gyr_bad;
   logic signed [15:0] acc_data;
   logic signed [15:0] gyr_data;
   logic signed [15:0] acc_qdata;
   logic signed [15:0] gyr_qdata;
   logic acc_qupd;
   logic gyr_qupd;

   // ****************************************************
   // power up sequence
   // ****************************************************
   always_ff @(posedge i_mclk)
   begin
      if (i_rst)
      begin
         por_cnt_reg <= 23'h00_0000;
         ready_reg <= 1'b0;
      end
      else if (!ready_reg)
      begin
         por_cnt_reg <= por_cnt_reg + 23'h00_0001;
         if (por_cnt_reg == 23'(P_POWERUP_CYC - 1))
            ready_reg <= 1'b1;
      end
   end

   assign o_ready = ready_reg;

   // ****************************************************
   // sensor time
   // ****************************************************
   assign tick = div_reg == 12'(impmc_pkg::TICK_CYC - 1);
   assign next_time = time_reg + 24'h00_0001;

   always_ff @(posedge i_mclk)
   begin
      if (i_rst)
      begin
         div_reg <= 12'h000;
         time_reg <= 24'h00_0000;
      end
      else if (tick)
      begin
         div_reg <= 12'h000;
         time_reg <= next_time;
      end
      else
         div_reg <= div_reg + 12'h001;
   end

   // ****************************************************
   // register bus slave
   // ****************************************************
   assign req = i_avs_read | i_avs_write;
   assign idx = i_avs_address[9:2];
   assign wr_take = i_avs_write & ack_reg;
   assign o_avs_waitrequest = !ready_reg | (req & !ack_reg);

   always_ff @(posedge i_mclk)
   begin
      if (i_rst)
         ack_reg <= 1'b0;
      else
         ack_reg <= req & ready_reg & !ack_reg;
   end

   always_ff @(posedge i_mclk)
   begin
      if (i_rst)
         o_avs_readdata <= 32'h0000_0000;
      else if (i_avs_read & ready_reg & !ack_reg)
         o_avs_readdata <= rd_mux;
   end

   always_comb
   begin
      rd_mux = 32'h0000_0000;
      case (idx)
         impmc_pkg::IDX_ERR: rd_mux = {24'h00_0000, err_reg};
         impmc_pkg::IDX_PMU_STATUS:
            rd_mux = {24'h00_0000, ready_reg, o_accel_lp_clock,
                      o_accel_analog_on, gyr_state_reg == impmc_pkg::GYR_START,
                      gyr_code, acc_mode_reg};
         impmc_pkg::IDX_GYR_DATA: rd_mux = {16'h0000, gyr_data};
         impmc_pkg::IDX_ACC_DATA: rd_mux = {16'h0000, acc_data};
         impmc_pkg::IDX_TIME: rd_mux = {8'h00, time_reg};
         impmc_pkg::IDX_QUEUE_DATA: rd_mux = {gyr_qdata, acc_qdata};
         impmc_pkg::IDX_ACCEL_RATE_FILTER_CONFIG: rd_mux = {24'h00_0000, accel_rate_filter_config_reg};
         impmc_pkg::IDX_ROTATION_RATE_FILTER_CONFIG: rd_mux = {24'h00_0000, rotation_rate_filter_config_reg};
         impmc_pkg::IDX_QUEUE_DECIM:
            rd_mux = {24'h00_0000, queue_decim_reg};
         default: rd_mux = 32'h0000_0000;
      endcase
   end

   // ****************************************************
   // configuration registers
   // ****************************************************
   always_ff @(posedge i_mclk)
   begin
      if (i_rst)
      begin
         accel_rate_filter_config_reg <= impmc_pkg::ACCEL_RATE_FILTER_CONFIG_RST;
         rotation_rate_filter_config_reg <= impmc_pkg::ROTATION_RATE_FILTER_CONFIG_RST;
         queue_decim_reg <= impmc_pkg::QUEUE_DECIM_RST;
      end
      else if (wr_take & i_avs_byteenable[0])
      begin
         if (idx == impmc_pkg::IDX_ACCEL_RATE_FILTER_CONFIG)
            accel_rate_filter_config_reg <= i_avs_writedata[7:0];
         if (idx == impmc_pkg::IDX_ROTATION_RATE_FILTER_CONFIG)
            rotation_rate_filter_config_reg <= i_avs_writedata[7:0];
         if (idx == impmc_pkg::IDX_QUEUE_DECIM)
            queue_decim_reg <= i_avs_writedata[7:0];
      end
   end

   assign acc_odr = accel_rate_filter_config_reg[impmc_pkg::ACC_ODR_LSB +: 4];
   assign acc_avg = accel_rate_filter_config_reg[impmc_pkg::ACC_AVG_LSB +: 3];
   assign accel_undersample_enable = accel_rate_filter_config_reg[impmc_pkg::ACCEL_UNDERSAMPLE_ENABLE_BIT];
   assign acc_odr_bit = impmc_pkg::ODR_BIT_BASE - {1'b0, acc_odr};
   assign gyr_odr_bit = impmc_pkg::ODR_BIT_BASE -
                        {1'b0, rotation_rate_filter_config_reg[impmc_pkg::GYR_ODR_LSB +: 4]};

   // ****************************************************
   // error code
   // ****************************************************
   assign acc_bad = acc_odr < impmc_pkg::ACC_ODR_MIN ||
                    acc_odr > impmc_pkg::ACC_ODR_MAX ||
                    (!accel_undersample_enable && acc_odr < impmc_pkg::ACC_ODR_MIN_NUS);
   assign gyr_bad =
      rotation_rate_filter_config_reg[impmc_pkg::GYR_ODR_LSB +: 4] < impmc_pkg::GYR_ODR_MIN ||
      rotation_rate_filter_config_reg[impmc_pkg::GYR_ODR_LSB +: 4] > impmc_pkg::GYR_ODR_MAX;

   always_ff @(posedge i_mclk)
   begin
      if (i_rst)
         err_reg <= 8'h00;
      else
      begin
         err_reg <= 8'h00;
         err_reg[impmc_pkg::ERR_ACC_BIT] <= acc_bad;
         err_reg[impmc_pkg::ERR_GYR_BIT] <= gyr_bad;
      end
   end

   // ****************************************************
   // mode requests
   // ****************************************************
   assign cmd_we = wr_take & i_avs_byteenable[0] &
                   (idx == impmc_pkg::IDX_MODE_CMD);
   assign acc_req = i_avs_writedata[impmc_pkg::MODE_ACC_LSB +: 2];
   assign gyr_req = i_avs_writedata[impmc_pkg::MODE_GYR_LSB +: 2];
   assign gyr_code = (gyr_state_reg == impmc_pkg::GYR_NORMAL ||
                      gyr_state_reg == impmc_pkg::GYR_START) ?
                     impmc_pkg::GYR_CMD_NORMAL :
                     (gyr_state_reg == impmc_pkg::GYR_FSU) ?
                     impmc_pkg::GYR_CMD_FSU : impmc_pkg::GYR_CMD_SUSPEND;
   assign acc_chg = acc_req != 2'h3 && acc_req != acc_mode_reg;
   assign gyr_chg = gyr_req != 2'h2 && gyr_req != gyr_code;

   always_ff @(posedge i_mclk)
   begin
      if (i_rst)
         acc_mode_reg <= impmc_pkg::ACC_SUSPEND;
      else if (cmd_we && acc_chg && !gyr_chg)
         acc_mode_reg <= impmc_pkg::impmc_acc_mode_t'(acc_req);
   end

   // ****************************************************
   // gyro state machine
   // ****************************************************
   always_ff @(posedge i_mclk)
   begin
      if (i_rst)
      begin
         gyr_state_reg <= impmc_pkg::GYR_SUSPEND;
         gyr_timer_reg <= 23'h00_0000;
      end
      else if (cmd_we && gyr_chg && !acc_chg)
      begin
         case (gyr_req)
            impmc_pkg::GYR_CMD_NORMAL:
            begin
               gyr_state_reg <= impmc_pkg::GYR_START;
               if (gyr_state_reg == impmc_pkg::GYR_FSU)
                  gyr_timer_reg <= 23'(P_GYR_FSU_CYC - 1);
               else
                  gyr_timer_reg <= 23'(P_GYR_SU_CYC - 1);
            end
            impmc_pkg::GYR_CMD_FSU: gyr_state_reg <= impmc_pkg::GYR_FSU;
            default: gyr_state_reg <= impmc_pkg::GYR_SUSPEND;
         endcase
      end
      else
      begin
         case (gyr_state_reg)
            impmc_pkg::GYR_START:
            begin
               if (gyr_timer_reg == 23'h00_0000)
                  gyr_state_reg <= impmc_pkg::GYR_NORMAL;
               else
                  gyr_timer_reg <= gyr_timer_reg - 23'h00_0001;
            end
            impmc_pkg::GYR_SUSPEND,
            impmc_pkg::GYR_NORMAL,
            impmc_pkg::GYR_FSU: gyr_state_reg <= gyr_state_reg;
            default: gyr_state_reg <= impmc_pkg::GYR_SUSPEND;
         endcase
      end
   end

   // fast start keeps the drive running, so analog is only off in suspend
   assign gyr_active = gyr_state_reg == impmc_pkg::GYR_NORMAL;
   assign o_gyro_analog_on = gyr_state_reg != impmc_pkg::GYR_SUSPEND;

   // ****************************************************
   // accel duty cycling
   // ****************************************************
   assign acc_mask = (24'h1 << acc_odr_bit) - 24'h1;
   assign acc_phase = time_reg & acc_mask;
   assign acc_interval = 24'h1 << acc_odr_bit;
   // one sample at 1600 Hz lasts sixteen sensor time ticks
   assign acc_window = 24'(impmc_pkg::SETTLE_TICKS) +
                       (24'h10 << acc_avg);
   assign gap_short = acc_window >= acc_interval;
   assign awake = gap_short || acc_phase < acc_window;
   assign acc_active = acc_mode_reg != impmc_pkg::ACC_SUSPEND;

   // same gate in normal and low power keeps the data identical
   assign acc_sample_en = acc_active & (!accel_undersample_enable | awake);
   assign o_accel_analog_on = acc_active &
      (acc_mode_reg == impmc_pkg::ACC_NORMAL | !accel_undersample_enable | awake);
   assign o_accel_lp_clock =
      acc_mode_reg == impmc_pkg::ACC_LOWPOWER & !gap_short;

   // ****************************************************
   // data streams
   // ****************************************************
   impmc_stream u_acc_stream
   (
      .i_mclk(i_mclk),
      .i_rst(i_rst),
      .i_tick(tick),
      .i_next_time(next_time),
      .i_rate_bit(impmc_pkg::ACC_RATE_BIT),
      .i_odr_bit(acc_odr_bit),
      .i_downs(queue_decim_reg[impmc_pkg::QD_ACC_LSB +: 3]),
      .i_active(acc_active),
      .i_sample_en(acc_sample_en),
      .i_raw(i_accel_raw),
      .o_data(acc_data),
      .o_update(o_accel_update),
      .o_queue_data(acc_qdata),
      .o_queue_update(acc_qupd)
   );

   impmc_stream u_gyr_stream
   (
      .i_mclk(i_mclk),
      .i_rst(i_rst),
      .i_tick(tick),
      .i_next_time(next_time),
      .i_rate_bit(impmc_pkg::GYR_RATE_BIT),
      .i_odr_bit(gyr_odr_bit),
      .i_downs(queue_decim_reg[impmc_pkg::QD_GYR_LSB +: 3]),
      .i_active(gyr_active),
      .i_sample_en(gyr_active),
      .i_raw(i_gyro_raw),
      .o_data(gyr_data),
      .o_update(o_gyro_update),
      .o_queue_data(gyr_qdata),
      .o_queue_update(gyr_qupd)
   );

   assign o_queue_update = acc_qupd | gyr_qupd;

endmodule : impmc_power_mode_control

//--- design/impmc_stream.sv
`timescale 1ns/1ps

module impmc_stream
(
   input wire logic i_mclk,
   input wire logic i_rst,
   input wire logic i_tick,
   input wire logic [23:0] i_next_time,
   input wire logic [4:0] i_rate_bit,
   input wire logic [4:0] i_odr_bit,
   input wire logic [2:0] i_downs,
   input wire logic i_active,
   input wire logic i_sample_en,
   input wire logic signed [15:0] i_raw,
   output logic signed [15:0] o_data,
   output logic o_update,
   output logic signed [15:0] o_queue_data,
   output logic o_queue_update
);

   logic signed [15:0] filt_reg;
   logic [4:0] queue_bit;
   logic sample_hit;
   logic odr_hit;
   logic queue_hit;

   // true when the sensor time boundary of bit b is crossed
   function automatic logic hit(input logic [23:0] t, input logic [4:0] b);
      logic [23:0] mask;
      mask = (24'h1 << b) - 24'h1;
      return (t & mask) == 24'h0;
   endfunction : hit

   assign queue_bit = 5'(i_odr_bit + {2'b00, i_downs});
   assign sample_hit = i_tick & hit(i_next_time, i_rate_bit);
   assign odr_hit = i_tick & i_active & hit(i_next_time, i_odr_bit);
   assign queue_hit = i_tick & i_active & hit(i_next_time, queue_bit);

   // ****************************************************
   // fixed rate sampling and low pass
   // ****************************************************
   always_ff @(posedge i_mclk)
   begin
      if (i_rst)
         filt_reg <= 16'sh0000;
      else if (sample_hit & i_sample_en)
         filt_reg <= filt_reg - (filt_reg >>> 2) + (i_raw >>> 2);
   end

   // ****************************************************
   // output rate decimation
   // ****************************************************
   always_ff @(posedge i_mclk)
   begin
      if (i_rst)
      begin
         o_data <= 16'sh0000;
         o_update <= 1'b0;
      end
      else
      begin
         o_update <= odr_hit;
         if (odr_hit)
            o_data <= filt_reg;
      end
   end

   // whole frames between queue updates are dropped
   always_ff @(posedge i_mclk)
   begin
      if (i_rst)
      begin
         o_queue_data <= 16'sh0000;
         o_queue_update <= 1'b0;
      end
      else
      begin
         o_queue_update <= queue_hit;
         if (queue_hit)
            o_queue_data <= filt_reg;
      end
   end

endmodule : impmc_stream

//--- verification/impmc_power_mode_control_assertions.sv
`timescale 1ns/1ps

module impmc_power_mode_control_assertions
(
   input wire logic i_mclk,
   input wire logic i_rst,
   input wire logic [9:0] i_avs_address,
   input wire logic i_avs_read,
   input wire logic i_avs_write,
   input wire logic [31:0] i_avs_writedata,
   input wire logic [3:0] i_avs_byteenable,
   input wire logic [31:0] o_avs_readdata,
   input wire logic o_avs_waitrequest,
   input wire logic signed [15:0] i_accel_raw,
   input wire logic signed [15:0] i_gyro_raw,
   input wire logic o_accel_analog_on,
   input wire logic o_gyro_analog_on,
   input wire logic o_accel_lp_clock,
   input wire logic o_accel_update,
   input wire logic o_gyro_update,
   input wire logic o_queue_update,
   input wire logic o_ready
);
   default clocking cb @(posedge i_mclk);
   endclocking
   default disable iff (i_rst);

   // ****************************************************
   // sequences
   // ****************************************************
   sequence s_new_req;
      o_ready && o_avs_waitrequest && (i_avs_read || i_avs_write);
   endsequence
   sequence s_ack;
      !o_avs_waitrequest;
   endsequence

   // ****************************************************
   // properties
   // ****************************************************
   AST_RESET_STALL: assert property (
      $fell(i_rst) |-> o_avs_waitrequest && !o_ready)
      else $error("bus not stalled after reset");
   AST_NO_ACCESS_BEFORE_READY: assert property (
      !o_ready |-> o_avs_waitrequest)
      else $error("access completed before power-up done");
   AST_READY_HOLDS: assert property (o_ready |=> o_ready)
      else $error("ready dropped without reset");
   AST_ONE_WAIT: assert property (s_new_req |=> s_ack)
      else $error("access not answered after one wait state");
   AST_GYR_SUSPEND_QUIET: assert property (
      !o_gyro_analog_on && !$past(o_gyro_analog_on) |-> !o_gyro_update)
      else $error("gyro update while powered off");
   AST_ACC_SUSPEND_QUIET: assert property (
      (!o_accel_analog_on && !o_accel_lp_clock) [*2] |-> !o_accel_update)
      else $error("accel update while in suspend");
   AST_GYR_UPDATE_NEEDS_POWER: assert property (
      o_gyro_update |-> $past(o_gyro_analog_on))
      else $error("gyro update without acquisition");
   AST_QUEUE_SUBSET: assert property (
      o_queue_update |-> o_accel_update || o_gyro_update)
      else $error("queue frame without data update");
   AST_ACC_PULSE: assert property (
      o_accel_update |=> !o_accel_update [*8])
      else $error("accel updates too close");
   AST_GYR_PULSE: assert property (
      o_gyro_update |=> !o_gyro_update [*8])
      else $error("gyro updates too close");
endmodule : impmc_power_mode_control_assertions

bind impmc_power_mode_control impmc_power_mode_control_assertions u_chk
(
   .i_mclk, .i_rst, .i_avs_address, .i_avs_read, .i_avs_write,
   .i_avs_writedata, .i_avs_byteenable, .o_avs_readdata,
   .o_avs_waitrequest, .i_accel_raw, .i_gyro_raw, .o_accel_analog_on,
   .o_gyro_analog_on, .o_accel_lp_clock, .o_accel_update,
   .o_gyro_update, .o_queue_update, .o_ready
);

//--- verification/impmc_sensor_src.sv
`timescale 1ns/1ps

// front-end model: ramps so the filter sees moving input
module impmc_sensor_src
(
   input wire logic i_mclk,
   input wire logic i_rst,
   output logic signed [15:0] o_accel_raw,
   output logic signed [15:0] o_gyro_raw
);
   always_ff @(posedge i_mclk)
   begin
      if (i_rst)
      begin
         o_accel_raw <= 16'sh0100;
         o_gyro_raw <= -16'sh0200;
      end
      else
      begin
         o_accel_raw <= o_accel_raw + 16'sh0001;
         o_gyro_raw <= o_gyro_raw - 16'sh0003;
      end
   end
endmodule : impmc_sensor_src

//--- verification/tb_top.sv
`timescale 1ns/1ps

module tb_top;
   logic i_mclk = 1'b0;
   logic i_rst = 1'b1;
   logic [9:0] addr = 10'h000;
   logic rd = 1'b0;
   logic wr = 1'b0;
   logic [31:0] wdata = 32'h0000_0000;
   logic [3:0] be = 4'h1;
   logic [31:0] rdata;
   logic wait_req;
   logic signed [15:0] acc_raw;
   logic signed [15:0] gyr_raw;
   logic acc_on, gyr_on, lp_clk, acc_upd, gyr_upd, q_upd, ready;
   int fail_count = 0;
   int cmp_count = 0;
   int cycles = 0;
   logic asleep;
   logic [31:0] held;
   // scaled-down spacing after single writes while every sensor sleeps
   localparam int WR_GAP_CYC = 40;

   assign asleep = !gyr_on && (!acc_on || lp_clk);

   initial forever #5 i_mclk = ~i_mclk;

   impmc_sensor_src u_src
   (
      .i_mclk(i_mclk), .i_rst(i_rst),
      .o_accel_raw(acc_raw), .o_gyro_raw(gyr_raw)
   );

   impmc_power_mode_control
   #(
      .P_POWERUP_CYC(20), .P_GYR_SU_CYC(30), .P_GYR_FSU_CYC(10)
   )
   u_dut
   (
      .i_mclk(i_mclk), .i_rst(i_rst), .i_avs_address(addr),
      .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wdata),
      .i_avs_byteenable(be), .o_avs_readdata(rdata),
      .o_avs_waitrequest(wait_req), .i_accel_raw(acc_raw),
      .i_gyro_raw(gyr_raw), .o_accel_analog_on(acc_on),
      .o_gyro_analog_on(gyr_on), .o_accel_lp_clock(lp_clk),
      .o_accel_update(acc_upd), .o_gyro_update(gyr_upd),
      .o_queue_update(q_upd), .o_ready(ready)
   );

   // ****************************************************
   // bus access
   // ****************************************************
   task automatic xfer(input logic w, input logic [7:0] idx,
                       input logic [7:0] d, output logic [31:0] q);
      if (!w && idx == 8'h24 && asleep)
      begin
         fail_count++;
         $display("CHECK FAILED at %0t: queue read while asleep", $time);
      end
      @(posedge i_mclk);
      addr <= {idx, 2'b00};
      rd <= ~w;
      wr <= w;
      wdata <= {24'h00_0000, d};
      do @(posedge i_mclk); while (wait_req !== 1'b0);
      q = rdata;
      rd <= 1'b0;
      wr <= 1'b0;
   endtask : xfer

   task automatic put(input logic [7:0] idx, input logic [7:0] d);
      logic [31:0] q;
      xfer(1'b1, idx, d, q);
      if (asleep)
         repeat (WR_GAP_CYC) @(posedge i_mclk);
   endtask : put

   task automatic chk(input logic [7:0] idx, input logic [7:0] mask,
                      input logic [7:0] exp);
      logic [31:0] q;
      xfer(1'b0, idx, 8'h00, q);
      cmp_count++;
      if ({q[31:8], q[7:0] & mask} !== {24'h00_0000, exp})
      begin
         fail_count++;
         $display("CHECK FAILED at %0t: reg %h got %h exp %h", $time, idx,
                  q, exp);
      end
   endtask : chk

   task automatic chkw(input logic [7:0] idx, input logic [31:0] exp);
      logic [31:0] q;
      xfer(1'b0, idx, 8'h00, q);
      cmp_count++;
      if (q !== exp)
      begin
         fail_count++;
         $display("CHECK FAILED at %0t: reg %h got %h exp %h", $time, idx,
                  q, exp);
      end
   endtask : chkw

   task automatic end_sim();
      $display("comparisons %0d, mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : end_sim

   always @(posedge i_mclk)
   begin
      cycles = cycles + 1;
      if (cycles == 90000)
      begin
         fail_count++;
         $display("CHECK FAILED at %0t: run hung", $time);
         end_sim();
      end
   end

   // ****************************************************
   // tests
   // ****************************************************
   initial
   begin
      repeat (16) @(posedge i_mclk);
      i_rst <= 1'b0;
      chk(8'h03, 8'hff, 8'h80);
      chk(8'h40, 8'hff, 8'h28);
      chk(8'h42, 8'hff, 8'h28);
      chk(8'h45, 8'hff, 8'h00);
      chk(8'h02, 8'hff, 8'h00);
      chk(8'h7e, 8'hff, 8'h00);
      chk(8'h30, 8'hff, 8'h00);
      $display("test reset values done");
      put(8'h45, 8'h20);
      chk(8'h45, 8'hff, 8'h20);
      put(8'h40, 8'h02);
      chk(8'h02, 8'hff, 8'h01);
      put(8'h40, 8'h82);
      chk(8'h02, 8'hff, 8'h00);
      put(8'h42, 8'h25);
      chk(8'h02, 8'hff, 8'h02);
      put(8'h42, 8'h2d);
      put(8'h02, 8'hff);
      chk(8'h02, 8'hff, 8'h00);
      be <= 4'h0;
      put(8'h40, 8'h05);
      be <= 4'h1;
      chk(8'h40, 8'hff, 8'h82);
      put(8'h40, 8'h28);
      chk(8'h40, 8'hff, 8'h28);
      $display("test configuration done");
      put(8'h7e, 8'h01);
      chk(8'h03, 8'hff, 8'ha1);
      put(8'h7e, 8'h06);
      chk(8'h03, 8'hff, 8'ha1);
      put(8'h7e, 8'h05);
      chk(8'h03, 8'hff, 8'hb5);
      do @(posedge i_mclk); while (gyr_upd !== 1'b1);
      chk(8'h18, 8'h07, 8'h00);
      xfer(1'b0, 8'h0c, 8'h00, held);
      chk(8'h03, 8'hff, 8'ha5);
      $display("test gyro start done");
      put(8'h7e, 8'h0d);
      chk(8'h03, 8'hff, 8'had);
      put(8'h7e, 8'h05);
      chk(8'h03, 8'hff, 8'hb5);
      repeat (12) @(posedge i_mclk);
      chk(8'h03, 8'hff, 8'ha5);
      put(8'h7e, 8'h09);
      chk(8'h03, 8'hff, 8'ha5);
      $display("test fast start done");
      put(8'h7e, 8'h01);
      put(8'h7e, 8'h02);
      chk(8'h03, 8'hdf, 8'hc2);
      put(8'h40, 8'h78);
      chk(8'h03, 8'hff, 8'ha2);
      chk(8'h40, 8'hff, 8'h78);
      put(8'h7e, 8'h01);
      chk(8'h03, 8'hff, 8'ha1);
      put(8'h7e, 8'h00);
      chk(8'h03, 8'hff, 8'h80);
      $display("test low power done");
      put(8'h40, 8'h2c);
      put(8'h7e, 8'h01);
      do @(posedge i_mclk); while (acc_upd !== 1'b1);
      chk(8'h18, 8'h0f, 8'h00);
      chkw(8'h0c, held);
      chkw(8'h24, {held[15:0], 16'h0000});
      $display("test data hold done");
      end_sim();
   end
endmodule : tb_top
